// >>> rtl/smop_otp_programmer.sv
// Supply-modulated programmer: instruction counter, shift register, OTP words.
// Assumes level-detector pulses and oscillator tick are synchronous to CLK_SYS.
`timescale 1ns/100ps
module smop_otp_programmer
	import smop_pkg::*;
#(
	parameter int OSC_DIV = CLK_HZ / OSC_HZ,
	parameter int TIMEOUT_TICKS = TICK_TIMEOUT,
	parameter logic [7:0] WORD_D_INIT = 8'hA5 // Arbitrary type code
)
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Level detector pulses
	input wire logic PROGRAM_ENTRY_LEVEL,
	input wire logic EXIT_LEVEL,
	input wire logic PRESTORE_LEVEL,
	input wire logic STORE_LEVEL,
	input wire logic MODULATION_STEP,
	// Outputs
	output logic RESET_PAD_OUT,
	output logic RESET_PAD_OE_N,
	output logic SUPPLY_LOAD_EN,
	output logic [2:0] INSTR_STATE,
	output logic [7:0] SHIFT_DATA,
	output logic [7:0] WORD_A,
	output logic [7:0] WORD_B,
	output logic [7:0] WORD_C
);

////////////////////////////////////////////////////////////////////////////////
// Oscillator tick divider

logic [15:0] div_cnt;
logic [15:0] next_div_cnt;
logic osc_tick;

always_comb
begin
	osc_tick = (div_cnt == 16'(OSC_DIV - 1));
	next_div_cnt = osc_tick ? 16'h0000 : div_cnt + 16'h0001;
end

always_ff @(posedge CLK_SYS)
begin
	if (!RST_N)
		div_cnt <= 16'h0000;
	else
		div_cnt <= next_div_cnt;
end

////////////////////////////////////////////////////////////////////////////////
// Interval classification

typedef enum logic [1:0]
{
	SMOP_IV_NONE = 2'b00,
	SMOP_IV_ADV = 2'b01,
	SMOP_IV_ZERO = 2'b10,
	SMOP_IV_ONE = 2'b11
} smop_iv_e;

function automatic smop_iv_e classify(input logic [TICK_CNT_W-1:0] t);
	if (t >= TICK_CNT_W'(TICK_FIRST - TICK_TOL) && t <= TICK_CNT_W'(TICK_FIRST + TICK_TOL))
		return SMOP_IV_ADV;
	if (t >= TICK_CNT_W'(TICK_SECOND - TICK_TOL) && t <= TICK_CNT_W'(TICK_SECOND + TICK_TOL))
		return SMOP_IV_ZERO;
	if (t >= TICK_CNT_W'(TICK_THIRD - TICK_TOL) && t <= TICK_CNT_W'(TICK_THIRD + TICK_TOL))
		return SMOP_IV_ONE;
	return SMOP_IV_NONE;
endfunction

// Measuring states drive the reset pad
function automatic logic is_meas(input logic [2:0] s);
	return s == ST_FREQ || s == ST_INHIB;
endfunction

// Write/check states share one control path
function automatic logic [2:0] ctrl_state(input logic [2:0] s);
	if (s == ST_WORD_A || s == ST_WORD_C)
		return ST_WORD_B;
	return s;
endfunction

////////////////////////////////////////////////////////////////////////////////
// Control state

logic [2:0] instr;
logic [2:0] next_instr;
logic [7:0] shreg;
logic [7:0] next_shreg;
logic have_ref;
logic next_have_ref;
logic [TICK_CNT_W-1:0] iv_cnt;
logic [TICK_CNT_W-1:0] next_iv_cnt;
logic [TICK_CNT_W-1:0] idle_cnt;
logic [TICK_CNT_W-1:0] next_idle_cnt;
logic prestored;
logic next_prestored;
logic [7:0] word_a;
logic [7:0] word_b;
logic [7:0] word_c;
logic [7:0] next_word_a;
logic [7:0] next_word_b;
logic [7:0] next_word_c;
logic [2:0] eff;
smop_iv_e iv;

always_comb
begin
	next_instr = instr;
	next_shreg = shreg;
	next_have_ref = have_ref;
	next_iv_cnt = iv_cnt;
	next_idle_cnt = idle_cnt;
	next_prestored = prestored;
	next_word_a = word_a;
	next_word_b = word_b;
	next_word_c = word_c;
	iv = classify(iv_cnt);
	// Shared control state for write/check load decode
	eff = ctrl_state(instr);
	if (osc_tick && instr != ST_IDLE)
	begin
		if (iv_cnt != '1)
			next_iv_cnt = iv_cnt + 1'b1;
		next_idle_cnt = idle_cnt + 1'b1;
	end
	if (PROGRAM_ENTRY_LEVEL)
	begin
		next_instr = ST_FREQ;
		next_shreg = SHIFT_RESET;
		next_have_ref = 1'b0;
		next_iv_cnt = '0;
		next_idle_cnt = '0;
		next_prestored = 1'b0;
	end
	else if (instr != ST_IDLE)
	begin
		if (STORE_LEVEL)
		begin
			if (prestored)
			begin
				unique case (instr)
					ST_WORD_A: next_word_a = shreg;
					ST_WORD_B: next_word_b = shreg;
					ST_WORD_C: next_word_c = shreg;
					default: next_word_a = word_a;
				endcase
			end
			next_instr = ST_IDLE;
		end
		else if (EXIT_LEVEL)
			next_instr = ST_IDLE;
		else if (idle_cnt >= TICK_CNT_W'(TIMEOUT_TICKS))
			next_instr = ST_IDLE;
		else if (PRESTORE_LEVEL)
			next_prestored = 1'b1;
		else if (MODULATION_STEP)
		begin
			next_iv_cnt = '0;
			next_idle_cnt = '0;
			next_have_ref = 1'b1;
			if (have_ref)
			begin
				unique case (iv)
					SMOP_IV_ADV:
					begin
						if (instr != ST_WORD_D)
							next_instr = instr + 3'h1;
					end
					SMOP_IV_ZERO: next_shreg = {1'b0, shreg[7:1]};
					SMOP_IV_ONE: next_shreg = {1'b1, shreg[7:1]};
					SMOP_IV_NONE: next_shreg = shreg;
				endcase
			end
		end
	end
end

always_ff @(posedge CLK_SYS)
begin
	if (!RST_N)
	begin
		instr <= ST_IDLE;
		shreg <= SHIFT_RESET;
		have_ref <= 1'b0;
		iv_cnt <= '0;
		idle_cnt <= '0;
		prestored <= 1'b0;
		word_a <= 8'h00;
		word_b <= 8'h00;
		word_c <= 8'h00;
	end
	else
	begin
		instr <= next_instr;
		shreg <= next_shreg;
		have_ref <= next_have_ref;
		iv_cnt <= next_iv_cnt;
		idle_cnt <= next_idle_cnt;
		prestored <= next_prestored;
		word_a <= next_word_a;
		word_b <= next_word_b;
		word_c <= next_word_c;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Measurement signal generator

logic [10:0] meas_cnt;
logic [10:0] next_meas_cnt;
logic meas_out;
logic next_meas_out;
logic [10:0] meas_half;
logic [6:0] inhib;

always_comb
begin
	inhib = word_a[7:1];
	if (instr == ST_FREQ)
		meas_half = 11'(FREQ_DIV / 2);
	else
		meas_half = 11'((FREQ_DIV + INHIB_STEP_TICKS * int'(inhib)) / 2);
	next_meas_cnt = meas_cnt;
	next_meas_out = meas_out;
	if (!is_meas(instr))
	begin
		next_meas_cnt = 11'h000;
		next_meas_out = 1'b0;
	end
	else if (osc_tick)
	begin
		if (meas_cnt + 11'h001 >= meas_half)
		begin
			next_meas_cnt = 11'h000;
			next_meas_out = ~meas_out;
		end
		else
			next_meas_cnt = meas_cnt + 11'h001;
	end
end

always_ff @(posedge CLK_SYS)
begin
	if (!RST_N)
	begin
		meas_cnt <= 11'h000;
		meas_out <= 1'b0;
	end
	else
	begin
		meas_cnt <= next_meas_cnt;
		meas_out <= next_meas_out;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Readback load and outputs

logic [7:0] sel_word;
logic hit;
logic load;
logic next_load;

always_comb
begin
	// States 3 and 5 are decoded as 4 for control; data words stay distinct
	unique case (instr)
		ST_WORD_A: sel_word = word_a;
		ST_WORD_B: sel_word = word_b;
		ST_WORD_C: sel_word = word_c;
		ST_WORD_D: sel_word = WORD_D_INIT;
		default: sel_word = 8'h00;
	endcase
	hit = |(shreg & sel_word);
	if (is_meas(instr))
		next_load = meas_out;
	else
		next_load = (eff >= ST_WORD_A) && hit;
end

always_ff @(posedge CLK_SYS)
begin
	if (!RST_N)
		load <= 1'b0;
	else
		load <= next_load;
end

assign RESET_PAD_OUT = meas_out;
assign RESET_PAD_OE_N = !is_meas(instr);
assign SUPPLY_LOAD_EN = load;
assign INSTR_STATE = instr;
assign SHIFT_DATA = shreg;
assign WORD_A = word_a;
assign WORD_B = word_b;
assign WORD_C = word_c;

endmodule

// >>> rtl/smop_pkg.sv
// Constants of the supply-modulated one-time-programmable word programmer.
// Assumes a 50 MHz system clock; level detector outputs arrive as synchronous pulses.
//
// Overview of operation
// - Six instruction states; states three and five share state four's control path but keep their own words.
// - State 2 measures inhibition; 3..5 write/check A, B, C; 6 checks D.
// - Eight-bit shift register stores a whole word; also bit pointer when checking.
// - Small pulse after first interval advances the instruction counter.
// - Small pulse after second interval shifts a zero into the register.
// - Small pulse after third interval shifts a one into the register.
// - First small pulse after entry only sets the timing reference.
// - Entry level pulse sets counter to state 1 and clears the register.
// - Exit level or store level pulse ends the active instruction state.
// - Two seconds without modulation pulses ends the instruction state.
// - Prestore then store pulse copies shift register into the selected word.
// - Pointer on a stored one connects the supply load resistor.
// - Measuring states drive reset pad; load follows the pad when high.
// - Measuring state 1 outputs oscillator divided by 1024.
// - Measuring state 2 period is base plus inhibition count times step.
// - Inhibition count is word A bits one to seven, bit seven most significant.
package smop_pkg;
	localparam int CLK_HZ = 50_000_000;
	localparam int OSC_HZ = 32_768;
	localparam int INSTR_W = 3;
	localparam logic [2:0] ST_IDLE = 3'h0;
	localparam logic [2:0] ST_FREQ = 3'h1;
	localparam logic [2:0] ST_INHIB = 3'h2;
	localparam logic [2:0] ST_WORD_A = 3'h3;
	localparam logic [2:0] ST_WORD_B = 3'h4;
	localparam logic [2:0] ST_WORD_C = 3'h5;
	localparam logic [2:0] ST_WORD_D = 3'h6;
	localparam logic [7:0] SHIFT_RESET = 8'h00;
	// Interval nominals in microseconds and acceptance tolerance
	localparam int FIRST_INTERVAL_US = 700;
	localparam int SECOND_INTERVAL_US = 1700;
	localparam int THIRD_INTERVAL_US = 2700;
	localparam int INTERVAL_TOL_US = 300;
	localparam int TIMEOUT_MS = 2000;
	// Oscillator ticks; interval nominals rounded to nearest, tolerance truncated
	localparam int TICK_FIRST = (FIRST_INTERVAL_US * OSC_HZ + 500_000) / 1_000_000;
	localparam int TICK_SECOND = (SECOND_INTERVAL_US * OSC_HZ + 500_000) / 1_000_000;
	localparam int TICK_THIRD = (THIRD_INTERVAL_US * OSC_HZ + 500_000) / 1_000_000;
	localparam int TICK_TOL = (INTERVAL_TOL_US * OSC_HZ) / 1_000_000;
	localparam int TICK_TIMEOUT = TIMEOUT_MS * OSC_HZ / 1000;
	// Measuring state 2: base 31.25 ms is 1024 ticks, step 0.122 ms is 4 ticks
	localparam int FREQ_DIV = 1024;
	localparam int INHIB_STEP_TICKS = 4;
	localparam int TICK_CNT_W = 17;
endpackage

// >>> dv/smop_otp_programmer_assertions.sv
// Port checker of the supply-modulated programmer.
// Assumes one clock domain and synchronous active-low reset.
`timescale 1ns/100ps
module smop_otp_programmer_assertions
	import smop_pkg::*;
#(
	parameter int OSC_DIV = 4,
	parameter int TIMEOUT_TICKS = 200
)
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Detector pulses
	input wire logic PROGRAM_ENTRY_LEVEL,
	input wire logic EXIT_LEVEL,
	input wire logic PRESTORE_LEVEL,
	input wire logic STORE_LEVEL,
	input wire logic MODULATION_STEP,
	// Outputs
	input wire logic RESET_PAD_OUT,
	input wire logic RESET_PAD_OE_N,
	input wire logic SUPPLY_LOAD_EN,
	input wire logic [2:0] INSTR_STATE,
	input wire logic [7:0] SHIFT_DATA,
	input wire logic [7:0] WORD_A,
	input wire logic [7:0] WORD_B,
	input wire logic [7:0] WORD_C
);
	int quiet;
	int next_quiet;
	always_comb
	begin
		next_quiet = quiet + 1;
		if (PROGRAM_ENTRY_LEVEL || MODULATION_STEP || INSTR_STATE == 3'h0)
			next_quiet = 0;
	end
	always_ff @(posedge CLK_SYS)
		quiet <= RST_N ? next_quiet : 0;
	////////////////////////////////////////////////////////////////////////////
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	AST_ENTRY: assert property (PROGRAM_ENTRY_LEVEL |=> INSTR_STATE == 3'h1 &&
		SHIFT_DATA == 8'h00) else $error("entry failed");
	AST_END: assert property ((EXIT_LEVEL || STORE_LEVEL) && !PROGRAM_ENTRY_LEVEL
		|=> INSTR_STATE == 3'h0) else $error("state not ended");
	AST_IDLE: assert property (INSTR_STATE == 3'h0 && !PROGRAM_ENTRY_LEVEL
		|=> INSTR_STATE == 3'h0) else $error("left idle");
	AST_RANGE: assert property (INSTR_STATE <= 3'h6) else $error("bad state");
	AST_STEP: assert property ($changed(INSTR_STATE) && INSTR_STATE != 3'h0 &&
		!$past(PROGRAM_ENTRY_LEVEL) |-> INSTR_STATE == $past(INSTR_STATE) + 3'h1)
		else $error("bad step");
	AST_SHIFT: assert property ($past(MODULATION_STEP) && $changed(SHIFT_DATA)
		|-> SHIFT_DATA[6:0] == $past(SHIFT_DATA[7:1])) else $error("bad shift");
	AST_PAD: assert property (RESET_PAD_OE_N == !(INSTR_STATE inside {3'h1, 3'h2}))
		else $error("pad enable wrong");
	AST_WORDS: assert property ($changed({WORD_A, WORD_B, WORD_C})
		|-> $past(STORE_LEVEL)) else $error("word changed");
	AST_IDLE_LOAD: assert property (INSTR_STATE == 3'h0 [*3]
		|-> !SUPPLY_LOAD_EN) else $error("load in idle");
	AST_TIMEOUT: assert property (quiet <= (TIMEOUT_TICKS + 2) * OSC_DIV)
		else $error("no timeout");
	AST_COV_ENTRY: cover property (PROGRAM_ENTRY_LEVEL);
	AST_COV_STORE: cover property (PRESTORE_LEVEL ##[1:4] STORE_LEVEL);
	AST_COV_LOAD: cover property ($rose(SUPPLY_LOAD_EN));
	AST_COV_PAD: cover property ($rose(RESET_PAD_OUT));
endmodule
bind smop_otp_programmer smop_otp_programmer_assertions
	#(.OSC_DIV(OSC_DIV), .TIMEOUT_TICKS(TIMEOUT_TICKS)) chk_i (.*);

// >>> dv/smop_tester.sv
// Tester model: one-cycle detector pulses, driven on the falling edge.
// Assumes the bench holds reset through oscillator start-up.
`timescale 1ns/100ps
module smop_tester
	import smop_pkg::*;
#(
	parameter int DIV = 4
)
(
	// Clock
	input wire logic CLK_SYS,
	// Detector pulses
	output logic PROGRAM_ENTRY_LEVEL,
	output logic EXIT_LEVEL,
	output logic PRESTORE_LEVEL,
	output logic STORE_LEVEL,
	output logic MODULATION_STEP
);
	logic [4:0] p = 5'h00;
	assign {MODULATION_STEP, STORE_LEVEL, PRESTORE_LEVEL, EXIT_LEVEL, PROGRAM_ENTRY_LEVEL} = p;
	// Pulse k: entry, exit, prestore, store, modulation
	task automatic hit(input int k);
		@(negedge CLK_SYS) p[k] = 1'b1;
		@(negedge CLK_SYS) p[k] = 1'b0;
	endtask
	// Modulation pulse t ticks after the last
	task automatic gap(input int t);
		repeat (t * DIV - 2) @(negedge CLK_SYS);
		hit(4);
	endtask
	// Entry, settle, timing reference
	task automatic enter();
		hit(0);
		repeat (40) @(negedge CLK_SYS);
		hit(4);
	endtask
	task automatic send(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			gap(v[i] ? TICK_THIRD : TICK_SECOND);
	endtask
	task automatic store();
		hit(2);
		hit(3);
	endtask
endmodule

// >>> dv/smop_otp_programmer_test.sv
// Testbench of the supply-modulated programmer.
// Assumes shortened oscillator divider and timeout.
`timescale 1ns/100ps
module smop_otp_programmer_test;
	import smop_pkg::*;
	localparam int DIV = 4;
	localparam int TMO = 3000;
	localparam logic [7:0] TYPE_CODE = 8'h3C; // Arbitrary type code
	logic CLK_SYS = 1'b0;
	logic RST_N = 1'b0;
	logic PROGRAM_ENTRY_LEVEL, EXIT_LEVEL, PRESTORE_LEVEL, STORE_LEVEL, MODULATION_STEP;
	logic RESET_PAD_OUT, RESET_PAD_OE_N, SUPPLY_LOAD_EN;
	logic [2:0] INSTR_STATE;
	logic [7:0] SHIFT_DATA, WORD_A, WORD_B, WORD_C;
	logic [7:0] v [3] = '{8'h0A, 8'hB5, 8'h6C};
	int fail_count = 0;
	int n_tests = 0;
	smop_otp_programmer #(.OSC_DIV(DIV), .TIMEOUT_TICKS(TMO),
		.WORD_D_INIT(TYPE_CODE)) dut (.*);
	smop_tester #(.DIV(DIV)) tester (.*);
	////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////
	task automatic t_load();
		for (int w = 0; w < 3; w++)
		begin
			tester.enter();
			repeat (w + 2) tester.gap(TICK_FIRST);
			tester.send(v[w]);
			chk(SHIFT_DATA, v[w]);
			tester.store();
			chk(INSTR_STATE, 3'h0);
		end
		chk({WORD_A, WORD_B}, {v[0], v[1]});
		chk(WORD_C, v[2]);
	endtask
	task automatic t_nostore();
		tester.enter();
		repeat (2) tester.gap(TICK_FIRST);
		tester.send(8'hFF);
		tester.hit(3);
		chk(INSTR_STATE, 3'h0);
		chk(WORD_A, v[0]);
	endtask
	task automatic t_read(input int s, input logic [7:0] w);
		int n;
		tester.enter();
		repeat (s - 1) tester.gap(TICK_FIRST);
		tester.gap(TICK_THIRD);
		for (int i = 7; i >= 0; i--)
		begin
			repeat (2) @(negedge CLK_SYS);
			chk(SUPPLY_LOAD_EN, w[i]);
			if (i > 0)
				tester.gap(TICK_SECOND);
		end
		tester.gap(40);
		chk(SHIFT_DATA, 8'h01);
		for (n = 0; n < (TMO + 9) * DIV && INSTR_STATE !== 3'h0; n++)
			@(negedge CLK_SYS);
		chk(n >= (TMO - 2) * DIV && n <= (TMO + 2) * DIV, 1'b1);
	endtask
	task automatic t_meas(input int s, input int half);
		int n;
		tester.enter();
		repeat (s - 1) tester.gap(TICK_FIRST);
		for (n = 0; n < 5000 && RESET_PAD_OUT !== 1'b0; n++)
			@(negedge CLK_SYS);
		for (n = 0; n < 5000 && RESET_PAD_OUT !== 1'b1; n++)
			@(negedge CLK_SYS);
		chk(n < 5000, 1'b1);
		repeat (10) @(negedge CLK_SYS);
		chk(SUPPLY_LOAD_EN, 1'b1);
		for (n = 10; n < 5000 && RESET_PAD_OUT === 1'b1; n++)
			@(negedge CLK_SYS);
		chk(n, half * DIV);
		tester.hit(1);
	endtask
	task automatic t_entry();
		tester.hit(0);
		chk({INSTR_STATE, SHIFT_DATA}, 11'h100);
		tester.gap(TICK_FIRST);
		chk(INSTR_STATE, 3'h1);
		for (int s = 2; s <= 7; s++)
		begin
			tester.gap(TICK_FIRST);
			chk(INSTR_STATE, s > 6 ? 6 : s);
		end
		tester.hit(1);
		chk(INSTR_STATE, 3'h0);
	endtask
	task automatic t_reset();
		tester.enter();
		RST_N = 1'b0;
		repeat (2) @(negedge CLK_SYS);
		chk({RESET_PAD_OE_N, INSTR_STATE, SUPPLY_LOAD_EN, WORD_A}, 13'h1000);
		chk({WORD_B, WORD_C}, 16'h0000);
		RST_N = 1'b1;
		tester.enter();
		chk(INSTR_STATE, 3'h1);
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	initial
	begin
		repeat (4) @(negedge CLK_SYS);
		chk({RESET_PAD_OE_N, INSTR_STATE, SUPPLY_LOAD_EN, WORD_A}, 13'h1000);
		RST_N = 1'b1;
		t_load();
		t_nostore();
		t_meas(1, 512);
		t_meas(2, (1024 + 4 * v[0][7:1]) / 2);
		t_read(3, v[0]);
		t_read(4, v[1]);
		t_read(5, v[2]);
		t_read(6, TYPE_CODE);
		t_entry();
		t_reset();
		finish_test();
	end
endmodule
